// ==== hw/afs_regs.svh ====
// Constants of the actuator fault supervisor: register map, fields, timing.
//
// Contract
// RL1: Solenoid drivers off while supply voltage is above 36 V.
// RL2: Solenoid drivers off while supply voltage is below 8.5 V.
// RL3: Solenoid drivers off while the internal clock supervisor reports failure.
// RL4: Supply or clock supervision never raises error, LED state or fault latch.
// RL5: Inactive error output is actively driven to ground.
// RL6: System must not tie error outputs together; signal-level load only.
// RL7: With direction option, both direction flags low while error is active.
// RL8: Solenoid supply off: setpoint not monitored, treated as 50 percent.
// RL9: Input fault check suppressed while solenoid supply is off.
// RL10: Flag low beyond 0.8 mm toward its side, high again within 0.4 mm.
// RL11: Movement toward A lowers only flag A; toward B only flag B.
// RL12: Neutral-off option: solenoids off while setpoint is 48 to 52 percent.
// RL13: Window entry to solenoids passive takes 750 ms to 1000 ms.
// RL14: Window exit to solenoids active takes 0 ms to 50 ms.
// RL15: In window, fault monitoring stays on; loop passive until setpoint changes.
// RL16: Neutral-off option drives solenoid status high active, low passive.
// RL17: Six-pin float variant has window disable but no status output.
// RL18: System should put unused actuators into the solenoid-disabled state.
// RL19: Active mode: 500 ms error disables bridge, raises error, latched to restart.
// RL20: Passive mode: 250 ms error raises error, held at least 100 ms.
// RL21: Setpoint outside 15 to 85 percent is an input-signal error.
// RL22: Delays counted on the clock, cleared when the cause goes away.
`ifndef AFS_REGS_SVH
`define AFS_REGS_SVH

`define AFS_CLK_MHZ         125
`define AFS_ERR_ACT_MS      500
`define AFS_ERR_PAS_MS      250
`define AFS_ERR_HOLD_MS     100
`define AFS_NP_OFF_MS       750
`define AFS_NP_ON_MS        0
`define AFS_ACT_CYC         (`AFS_ERR_ACT_MS * 1000 * `AFS_CLK_MHZ)
`define AFS_PAS_CYC         (`AFS_ERR_PAS_MS * 1000 * `AFS_CLK_MHZ)
`define AFS_HOLD_CYC        (`AFS_ERR_HOLD_MS * 1000 * `AFS_CLK_MHZ)
`define AFS_NPOFF_CYC       (`AFS_NP_OFF_MS * 1000 * `AFS_CLK_MHZ)

// Thresholds: supply in millivolts, setpoint in per-mille of supply.
`define AFS_SUP_HI_MV       16'h8CA0
`define AFS_SUP_LO_MV       16'h2134
`define AFS_SP_MIN_PM       10'h096
`define AFS_SP_MAX_PM       10'h352
`define AFS_NP_LO_PM        10'h1E0
`define AFS_NP_HI_PM        10'h208
`define AFS_SP_NEUTRAL_PM   10'h1F4
// Spool position in micrometres, signed, positive toward port B.
`define AFS_DIR_SET_UM      16'sh0320
`define AFS_DIR_CLR_UM      16'sh0190

// Register byte offsets.
`define AFS_REG_CTRL        12'h000
`define AFS_REG_STATUS      12'h004
`define AFS_REG_SUPPLY      12'h008
`define AFS_REG_SETPT       12'h00C
`define AFS_REG_SPOOL       12'h010
`define AFS_REG_ID          12'h014

// Control fields and reset value.
`define AFS_CTRL_ACTIVE     0
`define AFS_CTRL_DIROPT     1
`define AFS_CTRL_NPOPT      2
`define AFS_CTRL_FLOAT6     3
`define AFS_CTRL_SOLSUP     4
`define AFS_CTRL_RST        32'h0000_0017
// Status fields.
`define AFS_ST_ERR          0
`define AFS_ST_LATCH        1
`define AFS_ST_SUPV_OFF     2
`define AFS_ST_NP_OFF       3
`define AFS_ST_SOL_EN       4
`define AFS_ST_DIR_A        5
`define AFS_ST_DIR_B        6
`define AFS_ST_LOOP         7
`define AFS_ST_INERR        8

`endif

// ==== hw/afs_pkg.sv ====
// Types of the actuator fault supervisor.
package afs_pkg;
   typedef enum logic [1:0] {
      AFS_LED_GREEN = 2'b00,
      AFS_LED_FLASH = 2'b01,
      AFS_LED_RED   = 2'b10
   } afs_led_t;
   typedef enum logic [1:0] {
      AFS_NP_ON      = 2'b00,
      AFS_NP_WAIT    = 2'b01,
      AFS_NP_OFF     = 2'b10,
      AFS_NP_WAKE    = 2'b11
   } afs_np_t;
endpackage

// ==== hw/afs_top.sv ====
// Actuator fault supervisor: supervision, fault timing, direction, neutral off.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "afs_regs.svh"
module afs_top #(
   parameter int unsigned ACT_CYC   = `AFS_ACT_CYC,
   parameter int unsigned PAS_CYC   = `AFS_PAS_CYC,
   parameter int unsigned HOLD_CYC  = `AFS_HOLD_CYC,
   parameter int unsigned NPOFF_CYC = `AFS_NPOFF_CYC,
   parameter logic [31:0] ID_VALUE  = 32'h0000_A5C1
) (
   // Clock and reset.
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   // APB slave.
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Measurements from the analog front end.
   input  wire logic [15:0] SUPPLY_MV,
   input  wire logic [9:0]  SETPOINT_PM,
   input  wire logic [15:0] SPOOL_UM,
   input  wire logic        CLK_FAIL,
   input  wire logic        SOLENOID_SUPPLY_OK,
   input  wire logic        SENSOR_FAULT,
   input  wire logic        LOOP_FAULT,
   // Error pin, drive low when no error; enable low means driving.
   output logic             ERR_OUT,
   output logic             ERR_OE_N,
   // Status pins.
   output logic             DIR_FLAG_A,
   output logic             DIR_FLAG_B,
   output logic             SOL_STATUS,
   output logic             SOL_ENABLE,
   output logic             LOOP_ACTIVE,
   output logic [1:0]       LED_STATE
);
   // The clock-fail and supply-ok pins are asynchronous; the analog
   // words are assumed to arrive already registered on SYS_CLK.
   logic [2:0] cf_sync_ff, ss_sync_ff;
   logic       cf_ff, ss_ff;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cf_sync_ff <= 3'h0;
         ss_sync_ff <= 3'h0;
         cf_ff      <= 1'b0;
         ss_ff      <= 1'b0;
      end else begin
         cf_sync_ff <= {cf_sync_ff[1:0], CLK_FAIL};
         ss_sync_ff <= {ss_sync_ff[1:0], SOLENOID_SUPPLY_OK};
         if (cf_sync_ff[1] == cf_sync_ff[2])
            cf_ff <= cf_sync_ff[2];
         if (ss_sync_ff[1] == ss_sync_ff[2])
            ss_ff <= ss_sync_ff[2];
      end
   end

   // Control register.
   logic [31:0] ctrl_ff;
   wire apb_wr = PSEL && PENABLE && PWRITE;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N)
         ctrl_ff <= `AFS_CTRL_RST;
      else if (apb_wr && PADDR == `AFS_REG_CTRL)
         ctrl_ff <= {27'h0, PWDATA[4:0]};
   end
   wire mode_active = ctrl_ff[`AFS_CTRL_ACTIVE];
   wire opt_dir     = ctrl_ff[`AFS_CTRL_DIROPT];
   wire opt_np      = ctrl_ff[`AFS_CTRL_NPOPT];
   wire opt_float6  = ctrl_ff[`AFS_CTRL_FLOAT6];
   // Dual supply only matters on direction variants; otherwise always on.
   wire sol_sup     = !(opt_dir && ctrl_ff[`AFS_CTRL_SOLSUP]) || ss_ff;

   // Supervision: never feeds the fault path.
   wire supv_off = (SUPPLY_MV > `AFS_SUP_HI_MV) || // RL1
                   (SUPPLY_MV < `AFS_SUP_LO_MV) || // RL2
                   cf_ff;                          // RL3

   // Effective setpoint: neutral when the solenoid supply is gone.
   wire [9:0] sp_eff = sol_sup ? SETPOINT_PM : `AFS_SP_NEUTRAL_PM; // RL8
   wire in_err  = sol_sup && ((sp_eff < `AFS_SP_MIN_PM) ||
                  (sp_eff > `AFS_SP_MAX_PM)); // RL21 RL9
   wire any_err = in_err || SENSOR_FAULT || LOOP_FAULT;

   // Fault timing.
   logic [31:0] err_cnt_ff, hold_cnt_ff;
   logic        latch_ff, perr_ff, in_kind_ff;
   wire [31:0]  err_lim = mode_active ? ACT_CYC : PAS_CYC;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N)
         err_cnt_ff <= 32'h0;
      else if (!any_err || latch_ff)
         err_cnt_ff <= 32'h0; // RL22
      else if (err_cnt_ff < err_lim)
         err_cnt_ff <= err_cnt_ff + 32'h1;
   end
   wire err_due = any_err && (err_cnt_ff == err_lim);

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N)
         latch_ff <= 1'b0;
      else if (mode_active && err_due)
         latch_ff <= 1'b1; // RL19
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         perr_ff     <= 1'b0;
         hold_cnt_ff <= 32'h0;
      end else if (!mode_active && err_due) begin
         perr_ff     <= 1'b1; // RL20
         hold_cnt_ff <= 32'h0;
      end else if (perr_ff) begin
         if (hold_cnt_ff < HOLD_CYC)
            hold_cnt_ff <= hold_cnt_ff + 32'h1;
         else if (!any_err)
            perr_ff <= 1'b0; // RL20
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N)
         in_kind_ff <= 1'b0;
      else if (err_due)
         in_kind_ff <= in_err;
   end
   wire err_on = latch_ff || perr_ff; // RL4

   // Direction flags with hysteresis.
   logic dir_a_ff, dir_b_ff;
   wire signed [15:0] pos = SPOOL_UM;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         dir_a_ff <= 1'b1;
         dir_b_ff <= 1'b1;
      end else begin
         if (pos <= -`AFS_DIR_SET_UM)
            dir_a_ff <= 1'b0; // RL10 RL11
         else if (pos > -`AFS_DIR_CLR_UM)
            dir_a_ff <= 1'b1; // RL10
         if (pos >= `AFS_DIR_SET_UM)
            dir_b_ff <= 1'b0; // RL10 RL11
         else if (pos < `AFS_DIR_CLR_UM)
            dir_b_ff <= 1'b1; // RL10
      end
   end

   // Neutral-window solenoid disable.
   wire in_win = (sp_eff >= `AFS_NP_LO_PM) &&
                 (sp_eff <= `AFS_NP_HI_PM); // RL12
   wire np_use = opt_np || opt_float6;
   afs_pkg::afs_np_t np_ff;
   logic [31:0]      np_cnt_ff;
   logic [9:0]       sp_park_ff;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         np_ff      <= afs_pkg::AFS_NP_ON;
         np_cnt_ff  <= 32'h0;
         sp_park_ff <= `AFS_SP_NEUTRAL_PM;
      end else begin
         case (np_ff)
            afs_pkg::AFS_NP_ON: begin
               np_cnt_ff <= 32'h0;
               if (np_use && in_win)
                  np_ff <= afs_pkg::AFS_NP_WAIT;
            end
            afs_pkg::AFS_NP_WAIT: begin
               if (!np_use || !in_win) begin
                  np_ff     <= afs_pkg::AFS_NP_ON; // RL22
                  np_cnt_ff <= 32'h0;
               end else if (np_cnt_ff >= NPOFF_CYC - 32'h2) begin
                  np_ff      <= afs_pkg::AFS_NP_OFF; // RL13
                  sp_park_ff <= sp_eff;
               end else
                  np_cnt_ff <= np_cnt_ff + 32'h1;
            end
            afs_pkg::AFS_NP_OFF: begin
               if (!np_use || !in_win)
                  np_ff <= afs_pkg::AFS_NP_ON; // RL14
               else if (sp_eff != sp_park_ff)
                  np_ff <= afs_pkg::AFS_NP_WAKE; // RL15
            end
            afs_pkg::AFS_NP_WAKE: begin
               np_ff <= (np_use && in_win) ? afs_pkg::AFS_NP_WAIT
                                           : afs_pkg::AFS_NP_ON;
               np_cnt_ff <= 32'h0;
            end
            default: np_ff <= afs_pkg::AFS_NP_ON;
         endcase
      end
   end
   wire np_off = (np_ff == afs_pkg::AFS_NP_OFF);

   // Outputs.
   wire sol_en = !supv_off && !latch_ff && !np_off && sol_sup; // RL1 RL19
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         SOL_ENABLE  <= 1'b0;
         SOL_STATUS  <= 1'b0;
         LOOP_ACTIVE <= 1'b0;
         ERR_OUT     <= 1'b0;
         DIR_FLAG_A  <= 1'b0;
         DIR_FLAG_B  <= 1'b0;
         LED_STATE   <= afs_pkg::AFS_LED_GREEN;
      end else begin
         SOL_ENABLE  <= sol_en;
         SOL_STATUS  <= opt_np && !opt_float6 && sol_en; // RL16 RL17
         LOOP_ACTIVE <= sol_en; // RL15
         ERR_OUT     <= err_on; // RL5
         DIR_FLAG_A  <= opt_dir && dir_a_ff && !err_on; // RL7
         DIR_FLAG_B  <= opt_dir && dir_b_ff && !err_on; // RL7
         if (!err_on)
            LED_STATE <= afs_pkg::AFS_LED_GREEN;
         else if (in_kind_ff)
            LED_STATE <= afs_pkg::AFS_LED_FLASH;
         else
            LED_STATE <= afs_pkg::AFS_LED_RED;
      end
   end
   // The error pin is always driven, high or low, so a quiet pin pulls down.
   assign ERR_OE_N = 1'b0; // RL5

   // APB read side, zero wait states.
   always_comb begin
      PRDATA = 32'h0;
      case (PADDR)
         `AFS_REG_CTRL:   PRDATA = ctrl_ff;
         `AFS_REG_STATUS: PRDATA = {23'h0, in_err, sol_en, DIR_FLAG_B,
                                    DIR_FLAG_A, sol_en, np_off, supv_off,
                                    latch_ff, err_on};
         `AFS_REG_SUPPLY: PRDATA = {16'h0, SUPPLY_MV};
         `AFS_REG_SETPT:  PRDATA = {22'h0, SETPOINT_PM};
         `AFS_REG_SPOOL:  PRDATA = {16'h0, SPOOL_UM};
         `AFS_REG_ID:     PRDATA = ID_VALUE;
         default:         PRDATA = 32'h0;
      endcase
   end
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && (PADDR[1:0] != 2'b00 ||
                    PADDR > `AFS_REG_ID);

   // Assertions.
   supv_off_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      supv_off |=> !SOL_ENABLE) else $error("solenoid on during supervision"); // RL1
   supv_err_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (supv_off && !any_err && !err_on) |=> !ERR_OUT)
      else $error("supervision raised error"); // RL4
   err_dir_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      err_on |=> (!DIR_FLAG_A && !DIR_FLAG_B)) else $error("flag high in error"); // RL7
   latch_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      latch_ff |=> latch_ff && !SOL_ENABLE) else $error("latch dropped"); // RL19
   in_sup_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      !sol_sup |-> !in_err) else $error("input check with supply off"); // RL9
   dir_neut_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (pos > -`AFS_DIR_CLR_UM && pos < `AFS_DIR_CLR_UM)[*2] |-> dir_a_ff && dir_b_ff)
      else $error("flag low at neutral"); // RL10
   np_wake_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (np_off && !in_win) |=> (np_ff == afs_pkg::AFS_NP_ON))
      else $error("slow wake"); // RL14
   sol_stat_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      opt_float6 |=> !SOL_STATUS) else $error("status on float variant"); // RL17
   perr_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      $fell(perr_ff) |-> $past(hold_cnt_ff) >= HOLD_CYC)
      else $error("passive error too short"); // RL20

   // A quiet fault path must leave the error pin at its low level.
   err_low_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RL5
      !err_on |=> !ERR_OUT) else $error("error pin high without fault");
   // Parking in the window drops both drive and its status line.
   np_sol_off_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RL12
      np_off |=> (!SOL_ENABLE && !SOL_STATUS))
      else $error("solenoids on while parked");
   // The parking delay may not be cut short by a stale counter.
   np_min_dly_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RL13
      $rose(np_off) |-> (np_cnt_ff >= NPOFF_CYC - 32'h2))
      else $error("parked too early");
   dir_one_side_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RL11
      !(!dir_a_ff && !dir_b_ff)) else $error("both flags low from spool");
   // Passive faults only report; the bridge keeps its drive.
   pas_drive_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RL20
      (perr_ff && !latch_ff && !supv_off && !np_off && sol_sup) |=>
      SOL_ENABLE) else $error("passive fault cut the drive");
   sup_neutral_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RL8
      !sol_sup |-> (sp_eff == `AFS_SP_NEUTRAL_PM))
      else $error("setpoint used with supply off");
   loop_sol_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RL15
      LOOP_ACTIVE == SOL_ENABLE) else $error("loop state differs from drive");
endmodule
`default_nettype wire

// ==== testbench/afs_ctrl_model.sv ====
// Machine controller model: reads the error pin, drives the setpoint.
`timescale 1ns/100ps
`default_nettype none
module afs_ctrl_model (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Actuator pins.
   input  wire logic       err_out,
   input  wire logic       err_oe_n,
   // Demand from the sequence.
   input  wire logic [9:0] demand,
   input  wire logic       idle,
   output logic [9:0]      setpoint,
   output logic            fault_seen
);
   logic err_wire;
   // Each error pin goes to its own light input, so a released pin reads low.
   assign err_wire = err_oe_n ? 1'b0 : err_out;
   // An actuator with no work is parked at neutral so its solenoids drop out.
   assign setpoint = idle ? 10'h1F4 : demand;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         fault_seen <= 1'b0;
      else
         fault_seen <= err_wire;
   end
endmodule
`default_nettype wire

// ==== testbench/afs_top_tb.sv ====
// Self-checking bench of the actuator fault supervisor.
`timescale 1ns/100ps
`default_nettype none
module afs_top_tb;
   localparam int unsigned ACT = 50, PAS = 25, HLD = 10, NPO = 75;
   logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic        clk_fail, sol_ok, sensor_fault, loop_fault, idle, probe;
   logic        err_out, err_oe_n, dir_a, dir_b, sol_st, sol_en, loop_on;
   logic        seen;
   logic [1:0]  led;
   logic [8:0]  pinv;
   logic [9:0]  demand, setpt;
   logic [11:0] paddr;
   logic [15:0] supply_mv, spool_um;
   logic [31:0] pwdata, prdata, seed;
   logic [32:0] exp_q[$], msk_q[$];
   logic [32:0] got, e, m;
   logic [15:0] sup[5] = '{16'h8CA1, 16'h8CA0, 16'h2133, 16'h2134, 16'h5DC0};
   logic [15:0] spl[6] = '{16'h0384, 16'h01F4, 16'h012C, 16'hFC7C,
                           16'hFE0C, 16'h0000};
   logic [1:0]  ab[6] = '{2'b10, 2'b10, 2'b11, 2'b01, 2'b01, 2'b11};
   localparam logic [4:0] SUP_EN = 5'b01010;
   int          failures, n_compared;

   afs_top #(.ACT_CYC(ACT), .PAS_CYC(PAS), .HOLD_CYC(HLD), .NPOFF_CYC(NPO))
   i_afs_top (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SUPPLY_MV(supply_mv), .SETPOINT_PM(setpt), .SPOOL_UM(spool_um),
      .CLK_FAIL(clk_fail), .SOLENOID_SUPPLY_OK(sol_ok),
      .SENSOR_FAULT(sensor_fault), .LOOP_FAULT(loop_fault),
      .ERR_OUT(err_out), .ERR_OE_N(err_oe_n), .DIR_FLAG_A(dir_a),
      .DIR_FLAG_B(dir_b), .SOL_STATUS(sol_st), .SOL_ENABLE(sol_en),
      .LOOP_ACTIVE(loop_on), .LED_STATE(led));
   afs_ctrl_model i_afs_ctrl_model (.clk(sys_clk), .rst_n(rst_n),
      .err_out(err_out), .err_oe_n(err_oe_n), .demand(demand),
      .idle(idle), .setpoint(setpt), .fault_seen(seen));

   assign pinv = {err_out, err_oe_n, dir_a, dir_b, sol_st, sol_en, loop_on,
                  led};

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic check(input logic [32:0] sv, input logic [32:0] ev);
      n_compared++;
      if (sv !== ev) begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, sv, ev);
      end
   endtask
   task automatic note(input logic [32:0] v, input logic [32:0] mk);
      exp_q.push_back(v);
      msk_q.push_back(mk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
         failures++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] v,
                     input logic [32:0] mk);
      note(v, mk);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic pins(input logic [8:0] v, input logic [8:0] mk);
      note({24'h0, v}, {24'h0, mk});
      @(posedge sys_clk);
      probe <= 1'b1;
      @(posedge sys_clk);
      probe <= 1'b0;
   endtask
   task automatic quiet(input string name);
      $display("Test %s done", name);
      @(posedge sys_clk);
      seed = xs(seed);
      demand <= 10'h0C8 + 10'(seed % 250);
      spool_um <= 16'(seed % 301);
      supply_mv <= 16'h5DC0;
      clk_fail <= 1'b0;
      sol_ok <= 1'b1;
      sensor_fault <= 1'b0;
      loop_fault <= 1'b0;
      idle <= 1'b0;
      cyc(6);
   endtask
   task automatic give_verdict();
      $display("Compared %0d, failed %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Results are judged at the edge after they settle, never at launch.
   always @(posedge sys_clk) begin
      if (probe === 1'b1 || (psel && penable && pready === 1'b1 && !pwrite))
      begin
         got = (probe === 1'b1) ? {24'h0, pinv} : {pslverr, prdata};
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         check(got & m, e & m);
      end
   end

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      cyc(20000);
      failures++;
      give_verdict();
   end

   initial begin
      {psel, penable, pwrite, clk_fail, sensor_fault, loop_fault} = 6'h00;
      {idle, probe, rst_n} = 3'h0;
      sol_ok = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      demand = 10'h12C;
      supply_mv = 16'h5DC0;
      spool_um = 16'h0000;
      seed = 32'h0000_A79E;
      failures = 0;
      n_compared = 0;
      cyc(3);
      rst_n <= 1'b1;
      quiet("power_on");
      rd(12'h000, 33'h0_0000_0017, 33'h1_FFFF_FFFF);
      rd(12'h018, 33'h1_0000_0000, 33'h1_0000_0000);
      apb(1'b1, 12'h000, 32'h0000_0016);
      rd(12'h000, 33'h0_0000_0016, 33'h1_FFFF_FFFF);
      pins(9'h07C, 9'h1FF);
      quiet("registers");
      foreach (sup[i]) begin
         @(posedge sys_clk);
         supply_mv <= sup[i];
         clk_fail <= (i == 4);
         cyc(8);
         pins({5'h0, SUP_EN[i], SUP_EN[i], 2'b00}, 9'h18F);
      end
      quiet("supervision");
      foreach (spl[i]) begin
         @(posedge sys_clk);
         spool_um <= spl[i];
         cyc(4);
         pins({2'b00, ab[i], 5'h00}, 9'h060);
      end
      quiet("direction");
      for (int k = 0; k < 3; k++) begin
         @(posedge sys_clk);
         sensor_fault <= (k == 0);
         loop_fault <= (k == 1);
         if (k == 2)
            demand <= 10'h384;
         cyc(PAS - 5);
         pins(9'h07C, 9'h1FF);
         cyc(6);
         pins({7'h42, (k == 2) ? 2'b01 : 2'b10}, 9'h16B);
         @(posedge sys_clk);
         sensor_fault <= 1'b0;
         loop_fault <= 1'b0;
         demand <= 10'h12C;
         pins(9'h100, 9'h100);
         cyc(HLD + 8);
         pins(9'h000, 9'h103);
      end
      quiet("passive");
      @(posedge sys_clk);
      sol_ok <= 1'b0;
      demand <= 10'h064;
      cyc(PAS + 10);
      pins(9'h000, 9'h103);
      quiet("supply_off");
      @(posedge sys_clk);
      idle <= 1'b1;
      cyc(NPO - 5);
      pins(9'h01C, 9'h01C);
      cyc(10);
      pins(9'h000, 9'h01C);
      @(posedge sys_clk);
      idle <= 1'b0;
      demand <= 10'h0FA;
      cyc(2);
      pins(9'h01C, 9'h01C);
      quiet("neutral");
      apb(1'b1, 12'h000, 32'h0000_0017);
      @(posedge sys_clk);
      sensor_fault <= 1'b1;
      cyc(ACT - 5);
      pins(9'h008, 9'h10B);
      cyc(8);
      pins(9'h102, 9'h10B);
      @(posedge sys_clk);
      sensor_fault <= 1'b0;
      cyc(HLD * 3);
      pins(9'h102, 9'h10B);
      check({32'h0, seen}, 33'h0_0000_0001);
      quiet("active");
      rst_n <= 1'b0;
      cyc(3);
      rst_n <= 1'b1;
      quiet("restart");
      pins(9'h07C, 9'h1FF);
      give_verdict();
   end
endmodule
`default_nettype wire
